// [fcpd_drive_model.sv]
// drive mechanism stand-in: seek completion and disk byte pacing
`timescale 1ns/1ps
module fcpd_drive_model
  import fcpd_pkg::*;
(
  input  wire logic        mclk,         // controller clock
  input  wire logic        rst_n,        // sync reset, active low
  input  wire logic        seek_req_reg, // seek request pulse
  input  wire logic        rw_go_reg,    // transfer running
  input  wire logic [15:0] nbytes,       // bytes under the head per sector
  output logic             seek_done,    // seek finished pulse
  output logic             byte_tick     // one disk byte passed
);
  logic [3:0]  seek_cnt;
  logic [15:0] left;
  // the head takes a few cycles to settle after a seek request
  always_ff @(posedge mclk) begin
    seek_cnt  <= !rst_n ? 4'h0 : seek_req_reg ? 4'h5 : (seek_cnt != 4'h0 ? seek_cnt - 4'h1 : 4'h0);
    seek_done <= rst_n && seek_cnt == 4'h1;
  end
  // the disk spins at its own pace: one byte every other cycle, whole sector only
  always_ff @(posedge mclk) begin
    byte_tick <= rst_n && rw_go_reg && left != 16'h0000 && !byte_tick;
    if (!rw_go_reg) left <= nbytes;
    else if (left != 16'h0000 && !byte_tick) left <= left - 16'h0001;
  end
endmodule : fcpd_drive_model

// [fcpd_param_decode.sv]
// parameter latch, sector byte sequencing and head timing for the floppy core
`timescale 1ns/1ps
`include "fcpd_params.svh"
module fcpd_param_decode
  import fcpd_pkg::*;
#(
  parameter int LOAD_UNIT_CYC   = `FCPD_LOAD_UNIT_CYC,   // cycles per head load unit
  parameter int UNLOAD_UNIT_CYC = `FCPD_UNLOAD_UNIT_CYC  // cycles per head unload unit
) (
  input  wire logic        mclk,                    // controller clock
  input  wire logic        rst_n,                   // sync reset, active low
  input  wire logic        ce,                      // clock enable
  // command phase fields
  input  wire logic        cmd_latch,               // pulse: take command fields
  input  wire logic        cmd_is_read,             // command reads data
  input  wire logic        cmd_is_write,            // command writes data
  input  wire logic        cmd_is_verify,           // command is verify
  input  wire logic        cmd_has_cylinder,        // command carries a cylinder
  input  wire logic        direction_in,            // relative seek direction
  input  wire logic        drive_select_low,        // drive select low bit
  input  wire logic        drive_select_high,       // drive select high bit
  input  wire logic [2:0]  sector_size_code,        // sector size code
  input  wire logic [7:0]  special_byte_count,      // special byte count
  input  wire logic        verify_count_enable,     // verify count mode
  input  wire logic [7:0]  last_sector_number,      // final sector on track
  input  wire logic [7:0]  inter_sector_gap_length, // third gap length
  input  wire logic [7:0]  gap_alter,               // second gap alteration
  input  wire logic        perpendicular_mode,      // perpendicular recording
  input  wire logic        head_side_number,        // disk side
  input  wire logic        double_density_select,   // density choice
  // configure and specify fields
  input  wire logic        cfg_write,               // pulse: configure fields
  input  wire logic        fifo_enable_low,         // fifo enable, active low
  input  wire logic [3:0]  fifo_threshold_field,    // fifo threshold
  input  wire logic [7:0]  precomp_start_track,     // precomp start track
  input  wire logic        implied_seek_enable,     // implied seek
  input  wire logic        lock_write,              // pulse: retention setting
  input  wire logic        lock_value,              // retention value
  input  wire logic        spec_write,              // pulse: specify fields
  input  wire logic [6:0]  head_load_delay,         // head load units
  input  wire logic [3:0]  head_unload_delay,       // head unload units
  input  wire logic        non_dma_flag,            // non-dma mode
  input  wire logic        dsr_reset,               // pulse: rate select reset
  input  wire logic        digital_output_register_reset, // pulse: output reg reset
  // execution
  input  wire logic        exec_start,              // pulse: begin execution
  input  wire logic        seek_done,               // pulse: seek finished
  input  wire logic        byte_tick,               // pulse: one disk byte moved
  input  wire logic        exec_end,                // pulse: execution finished
  input  wire logic [7:0]  host_wr_data,            // byte from host
  // outputs
  output logic             step_inward_reg,         // seek steps toward spindle
  output logic [1:0]       drive_num_reg,           // addressed drive
  output logic [14:0]      sector_len_reg,          // physical sector length
  output logic [14:0]      host_len_reg,            // bytes passed to host
  output logic             count_sectors_reg,       // count field is sectors
  output logic [7:0]       sectors_per_track_reg,   // verify sector count
  output logic [7:0]       last_sector_reg,         // final sector to move
  output logic [7:0]       gap2_adjust_reg,         // second gap adjust
  output logic [7:0]       gap3_len_reg,            // third gap length
  output logic             head_side_reg,           // disk side
  output logic             double_density_reg,      // mfm when high
  output logic             fifo_on_reg,             // data fifo enabled
  output logic [3:0]       fifo_thr_reg,            // fifo threshold
  output logic [7:0]       precomp_reg,             // precomp start track
  output logic             lock_reg,                // retention setting
  output logic             irq_per_byte_reg,        // interrupt each transfer
  output logic             dma_req_mode_reg,        // dma requests in use
  output logic             seek_req_reg,            // pulse: implied seek
  output logic             head_loaded_reg,         // head is loaded
  output logic             rw_go_reg,               // read or write may run
  output logic             host_pass_reg,           // byte goes to/from host
  output logic             crc_en_reg,              // byte enters check code
  output logic [7:0]       wr_byte_reg,             // byte written to disk
  output logic             sector_end_reg           // pulse: last sector byte
);

  // refuse unit lengths that the prescaler cannot count
  if (LOAD_UNIT_CYC < 1 || UNLOAD_UNIT_CYC < 1) begin : g_unit_chk
    $error("head timing units must be at least one cycle");
  end

  fcpd_state_t state_reg;
  logic        soft_rst;
  logic        is_read_reg;
  logic        is_write_reg;
  logic [6:0]  hld_reg;
  logic [3:0]  hud_reg;
  logic [31:0] pre_reg;
  logic [6:0]  unit_reg;
  logic [14:0] byte_cnt_reg;
  logic [14:0] host_len_next;
  logic [14:0] sector_len_next;
  logic        pre_wrap;
  logic        unit_up;

  // either register's reset bit acts as a software reset
  // both sources are same-clock pulses, so no synchroniser is needed
  assign soft_rst = dsr_reset | digital_output_register_reset; // see [R18]

  // sector length from size code; a code above the largest legal one gives the base length
  // the code is three bits wide, so the cap only guards a wider field later
  always_comb begin
    if (sector_size_code > `FCPD_SIZE_CODE_MAX)
      sector_len_next = `FCPD_SECT_BASE_LEN;
    else
      sector_len_next = `FCPD_SECT_BASE_LEN << sector_size_code; // see [R20]
    if (sector_size_code == 3'h0 && !(cmd_is_verify && verify_count_enable))
      host_len_next = {7'h00, special_byte_count}; // see [R3] [R8]
    else
      host_len_next = sector_len_next; // count field ignored here, see [R7]
  end

  // command fields held through execution so a new byte cannot disturb it
  // a latch outside idle is dropped silently; the host must wait for idle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      step_inward_reg       <= 1'h0;
      drive_num_reg         <= 2'h0;
      sector_len_reg        <= `FCPD_SECT_BASE_LEN;
      host_len_reg          <= `FCPD_SECT_BASE_LEN;
      count_sectors_reg     <= 1'h0;
      sectors_per_track_reg <= 8'h00;
      last_sector_reg       <= 8'h00;
      gap2_adjust_reg       <= 8'h00;
      gap3_len_reg          <= 8'h00;
      head_side_reg         <= 1'h0;
      double_density_reg    <= 1'h0;
      is_read_reg           <= 1'h0;
      is_write_reg          <= 1'h0;
    end else if (ce && cmd_latch && state_reg == FCPD_IDLE) begin // see [R22]
      step_inward_reg       <= direction_in; // see [R1]
      drive_num_reg         <= {drive_select_high, drive_select_low}; // see [R2]
      sector_len_reg        <= sector_len_next; // see [R20]
      host_len_reg          <= host_len_next; // see [R3]
      count_sectors_reg     <= cmd_is_verify & verify_count_enable; // see [R8]
      sectors_per_track_reg <= special_byte_count; // see [R8]
      last_sector_reg       <= last_sector_number; // see [R11]
      gap2_adjust_reg       <= perpendicular_mode ? gap_alter : 8'h00; // see [R12]
      gap3_len_reg          <= inter_sector_gap_length; // see [R13]
      head_side_reg         <= head_side_number; // see [R14]
      double_density_reg    <= double_density_select; // see [R19]
      is_read_reg           <= cmd_is_read;
      is_write_reg          <= cmd_is_write;
    end
  end

  // configure fields; a software reset reverts them only when unlocked
  // cfg_write wins a tie with a software reset so a fresh setting is never lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fifo_on_reg  <= ~`FCPD_FIFO_OFF_RST;
      fifo_thr_reg <= `FCPD_FIFO_THR_RST;
      precomp_reg  <= `FCPD_PRECOMP_RST;
    end else if (ce) begin
      if (cfg_write) begin
        fifo_on_reg  <= ~fifo_enable_low; // see [R9]
        fifo_thr_reg <= fifo_threshold_field;
        precomp_reg  <= precomp_start_track;
      end else if (soft_rst && !lock_reg) begin // see [R17]
        fifo_on_reg  <= ~`FCPD_FIFO_OFF_RST; // see [R9]
        fifo_thr_reg <= `FCPD_FIFO_THR_RST;
        precomp_reg  <= `FCPD_PRECOMP_RST;
      end
    end
  end

  // retention setting itself survives software reset
  // only its own pulse changes it, otherwise a reset could unlock itself
  always_ff @(posedge mclk) begin
    if (!rst_n)
      lock_reg <= `FCPD_LOCK_RST;
    else if (ce && lock_write)
      lock_reg <= lock_value; // see [R17]
  end

  // specify fields: head timing and transfer mode
  // reset values give short head waits until the host programs its own
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hld_reg          <= `FCPD_HLD_RST;
      hud_reg          <= `FCPD_HUD_RST;
      irq_per_byte_reg <= 1'h0;
      dma_req_mode_reg <= 1'h1;
    end else if (ce && spec_write) begin
      hld_reg          <= head_load_delay;
      hud_reg          <= head_unload_delay;
      irq_per_byte_reg <= non_dma_flag; // see [R21]
      dma_req_mode_reg <= ~non_dma_flag; // see [R21]
    end
  end

  // prescaler held clear outside the load and hold waits, restarted on each timed wait
  // 32 bits so one unload unit at the full clock rate cannot overflow; unit_reg counts the units
  assign pre_wrap = (state_reg == FCPD_LOAD) ?
                    (pre_reg == 32'(LOAD_UNIT_CYC - 1)) :
                    (pre_reg == 32'(UNLOAD_UNIT_CYC - 1));
  assign unit_up  = (state_reg == FCPD_LOAD) ? (unit_reg >= hld_reg) :
                    (unit_reg >= {3'h0, hud_reg});

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pre_reg  <= 32'h0000_0000;
      unit_reg <= 7'h00;
    end else if (ce) begin
      if (state_reg != FCPD_LOAD && state_reg != FCPD_HOLD) begin
        pre_reg  <= 32'h0000_0000;
        unit_reg <= 7'h00;
      end else if (pre_wrap) begin
        pre_reg  <= 32'h0000_0000;
        unit_reg <= unit_reg + 7'h01;
      end else begin
        pre_reg <= pre_reg + 32'h0000_0001;
      end
    end
  end

  // execution sequencer: optional seek, head load wait, transfer, unload wait
  // hold keeps the head down; a start there without a seek skips the load wait
  // a stray exec_end outside a transfer is ignored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg       <= FCPD_IDLE;
      seek_req_reg    <= 1'h0;
      head_loaded_reg <= 1'h0;
      rw_go_reg       <= 1'h0;
    end else if (ce) begin
      seek_req_reg <= 1'h0;
      unique case (state_reg)
        FCPD_IDLE, FCPD_HOLD: begin
          if (exec_start && (is_read_reg || is_write_reg)) begin
            if (implied_seek_enable && cmd_has_cylinder) begin // see [R10]
              seek_req_reg <= 1'h1;
              state_reg    <= FCPD_SEEK;
            end else if (head_loaded_reg) begin
              rw_go_reg <= 1'h1; // head already down, no reload wait
              state_reg <= FCPD_XFER;
            end else begin
              head_loaded_reg <= 1'h1;
              state_reg       <= FCPD_LOAD;
            end
          end else if (state_reg == FCPD_HOLD && unit_up) begin
            head_loaded_reg <= 1'h0; // see [R16]
            state_reg       <= FCPD_IDLE;
          end
        end
        FCPD_SEEK: begin
          if (seek_done) begin
            head_loaded_reg <= 1'h1;
            state_reg       <= FCPD_LOAD;
          end
        end
        FCPD_LOAD: begin
          if (unit_up) begin // see [R15]
            rw_go_reg <= 1'h1;
            state_reg <= FCPD_XFER;
          end
        end
        FCPD_XFER: begin
          if (exec_end) begin // see [R16]
            rw_go_reg <= 1'h0;
            state_reg <= FCPD_HOLD;
          end
        end
        default: state_reg <= FCPD_IDLE;
      endcase
    end
  end

  // byte sequencing inside one sector; the whole sector always moves on disk
  // pass and pad come from one compare, so a byte is never both sent and zeroed
  // a short count stops the host side only; the check code still sees every byte
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      byte_cnt_reg   <= 15'h0000;
      host_pass_reg  <= 1'h0;
      crc_en_reg     <= 1'h0;
      wr_byte_reg    <= 8'h00;
      sector_end_reg <= 1'h0;
    end else if (ce) begin
      sector_end_reg <= 1'h0;
      crc_en_reg     <= 1'h0;
      host_pass_reg  <= 1'h0;
      if (state_reg != FCPD_XFER) begin
        byte_cnt_reg <= 15'h0000;
      end else if (byte_tick) begin
        crc_en_reg    <= 1'h1; // see [R6]
        host_pass_reg <= byte_cnt_reg < host_len_reg; // see [R4]
        if (byte_cnt_reg < host_len_reg)
          wr_byte_reg <= host_wr_data;
        else
          wr_byte_reg <= 8'h00; // see [R5]
        if (byte_cnt_reg == sector_len_reg - 15'h0001) begin
          byte_cnt_reg   <= 15'h0000;
          sector_end_reg <= 1'h1;
        end else begin
          byte_cnt_reg <= byte_cnt_reg + 15'h0001;
        end
      end
    end
  end

endmodule : fcpd_param_decode

// [fcpd_param_decode_asserts.sv]
// port checker for the floppy command parameter decoder
`timescale 1ns/1ps
module fcpd_param_decode_chk
  import fcpd_pkg::*;
#(
  parameter int LOAD_UNIT_CYC   = 4,  // cycles per head load unit
  parameter int UNLOAD_UNIT_CYC = 8   // cycles per head unload unit
) (
  input wire logic        mclk, rst_n, ce, cmd_latch, cmd_is_verify, cmd_has_cylinder, // controls
  input wire logic        direction_in, drive_select_low, drive_select_high, verify_count_enable, // fields
  input wire logic [2:0]  sector_size_code,      // size code
  input wire logic [7:0]  special_byte_count,    // byte count field
  input wire logic        cfg_write, fifo_enable_low, lock_write, dsr_reset, // config
  input wire logic        digital_output_register_reset, exec_start, seek_done, // reset and run
  input wire logic        byte_tick, implied_seek_enable, // disk pacing and implied seek
  input wire logic        step_inward_reg, fifo_on_reg, lock_reg, seek_req_reg, // outputs
  input wire logic        head_loaded_reg, rw_go_reg, crc_en_reg, // head and bytes
  input wire logic [1:0]  drive_num_reg,         // addressed drive
  input wire logic [14:0] sector_len_reg, host_len_reg, // lengths
  input wire logic [3:0]  fifo_thr_reg,          // threshold
  input wire logic [7:0]  precomp_reg            // precomp track
);
  logic seek_wait_reg;
  logic exec_d_reg;
  // busy guess from the ports only; conservative so a latch is judged only when surely idle
  always_ff @(posedge mclk) begin
    exec_d_reg <= rst_n & ce & exec_start;
    if (!rst_n | seek_done) seek_wait_reg <= 1'h0;
    else if (seek_req_reg) seek_wait_reg <= 1'h1;
  end
  wire take = ce & cmd_latch & !head_loaded_reg & !rw_go_reg & !seek_wait_reg & !exec_d_reg;
  wire sreset = ce & (dsr_reset | digital_output_register_reset) & !cfg_write & !lock_write;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  step_dir_a: assert property (take |=> step_inward_reg == $past(direction_in))
    else $error("seek direction wrong");
  drive_sel_a: assert property (take |=> drive_num_reg == $past({drive_select_high, drive_select_low}))
    else $error("drive number wrong");
  size_len_a: assert property (take |=> sector_len_reg == (15'h0080 << $past(sector_size_code)))
    else $error("sector length wrong");
  host_len_a: assert property (take |=> host_len_reg == (($past(sector_size_code) == 3'h0 &&
    !($past(cmd_is_verify) && $past(verify_count_enable))) ? {7'h00, $past(special_byte_count)} :
    (15'h0080 << $past(sector_size_code))))
    else $error("host length wrong");
  fifo_pol_a: assert property (ce && cfg_write |=> fifo_on_reg == !$past(fifo_enable_low))
    else $error("fifo enable polarity wrong");
  soft_rst_a: assert property (sreset && !lock_reg |=> !fifo_on_reg && fifo_thr_reg == 4'h0 && precomp_reg == 8'h00)
    else $error("soft reset did not restore config");
  lock_keep_a: assert property (sreset && lock_reg |=> $stable(fifo_on_reg) && $stable(precomp_reg))
    else $error("locked config changed");
  seek_go_a: assert property (ce && exec_start && implied_seek_enable && cmd_has_cylinder && !head_loaded_reg
    && !rw_go_reg && !seek_wait_reg |=> seek_req_reg)
    else $error("implied seek missing");
  load_wait_a: assert property ($rose(rw_go_reg) |-> $past(head_loaded_reg, 3))
    else $error("transfer began before head load time");
  unload_a: assert property ($fell(rw_go_reg) |-> head_loaded_reg [*8])
    else $error("head unloaded early");
  crc_a: assert property (ce && byte_tick && rw_go_reg |=> crc_en_reg)
    else $error("byte missed by check code");
endmodule : fcpd_param_decode_chk
bind fcpd_param_decode fcpd_param_decode_chk #(.LOAD_UNIT_CYC(LOAD_UNIT_CYC), .UNLOAD_UNIT_CYC(UNLOAD_UNIT_CYC)) i_chk (.*);

// [fcpd_param_decode_test.sv]
// self-checking bench for the floppy command parameter decoder
`timescale 1ns/1ps
module fcpd_param_decode_test
  import fcpd_pkg::*;
;
  logic mclk = 1'h0, rst_n, ce, cmd_latch, cmd_is_read, cmd_is_write, cmd_is_verify, cmd_has_cylinder;
  logic direction_in, drive_select_low, drive_select_high, verify_count_enable, perpendicular_mode;
  logic head_side_number, double_density_select, cfg_write, fifo_enable_low, implied_seek_enable;
  logic lock_write, lock_value, spec_write, non_dma_flag, dsr_reset, digital_output_register_reset;
  logic exec_start, seek_done, byte_tick, exec_end, step_inward_reg, count_sectors_reg, head_side_reg;
  logic double_density_reg, fifo_on_reg, lock_reg, irq_per_byte_reg, dma_req_mode_reg, seek_req_reg;
  logic head_loaded_reg, rw_go_reg, host_pass_reg, crc_en_reg, sector_end_reg;
  logic [1:0]  drive_num_reg;
  logic [2:0]  sector_size_code;
  logic [3:0]  fifo_threshold_field, head_unload_delay, fifo_thr_reg;
  logic [6:0]  head_load_delay;
  logic [7:0]  special_byte_count, last_sector_number, inter_sector_gap_length, gap_alter, precomp_start_track;
  logic [7:0]  host_wr_data, sectors_per_track_reg, last_sector_reg, gap2_adjust_reg, gap3_len_reg, precomp_reg;
  logic [7:0]  wr_byte_reg;
  logic [14:0] sector_len_reg, host_len_reg;
  logic [15:0] nbytes;
  int          errors = 0, tests_run = 0, n_crc, n_pass, n_end, n_seek, n_bad;

  fcpd_param_decode #(.LOAD_UNIT_CYC(4), .UNLOAD_UNIT_CYC(8)) i_fcpd_param_decode (.*);
  fcpd_drive_model i_fcpd_drive_model (.*);

  // 200 MHz controller clock
  always #2.5 mclk = ~mclk;

  // tally the per-byte strobes of the running transfer
  always @(posedge mclk) begin
    if (crc_en_reg === 1'h1) n_crc++;
    if (crc_en_reg === 1'h1 && host_pass_reg === 1'h1) n_pass++;
    if (crc_en_reg === 1'h1 && cmd_is_write && wr_byte_reg !== (host_pass_reg === 1'h1 ? 8'hA5 : 8'h00)) n_bad++;
    if (sector_end_reg === 1'h1) n_end++;
    if (seek_req_reg === 1'h1) n_seek++;
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    s = 1'h1;
    tick;
    s = 1'h0;
    tick;
  endtask : pulse

  task automatic latch(logic [2:0] code, logic [7:0] sbc, logic dir, logic [1:0] drv);
    sector_size_code = code;
    special_byte_count = sbc;
    direction_in = dir;
    {drive_select_high, drive_select_low} = drv;
    pulse(cmd_latch);
  endtask : latch

  task automatic t_fields;
    for (int i = 0; i < 8; i++) begin
      cmd_is_read = 1'h1;
      perpendicular_mode = i[0];
      gap_alter = 8'h30 + i[7:0];
      double_density_select = i[1];
      head_side_number = i[2];
      last_sector_number = 8'h10 + i[7:0];
      inter_sector_gap_length = 8'h1B ^ i[7:0];
      latch(i[2:0], i == 0 ? 8'h05 : 8'hFF, i[0], {1'h0, i[1]});
      chk("step_inward", step_inward_reg, i[0]);
      chk("drive_num", drive_num_reg, i[1]);
      chk("sector_len", sector_len_reg, 32'h80 << i);
      chk("host_len", host_len_reg, i == 0 ? 32'h5 : 32'h80 << i);
      chk("gap2", gap2_adjust_reg, i[0] ? 8'h30 + i : 0);
      chk("gap3", gap3_len_reg, 8'h1B ^ i);
      chk("last_sector", last_sector_reg, 8'h10 + i);
      chk("side", head_side_reg, i[2]);
      chk("density", double_density_reg, i[1]);
    end
    cmd_is_verify = 1'h1;
    verify_count_enable = 1'h1;
    latch(3'h0, 8'h12, 1'h0, 2'h0);
    chk("count_mode", {count_sectors_reg, sectors_per_track_reg, host_len_reg}, {1'h1, 8'h12, 15'h80});
    special_byte_count = 8'h77;
    tick(3);
    chk("held", sectors_per_track_reg, 8'h12);
    cmd_is_verify = 1'h0;
    verify_count_enable = 1'h0;
    $display("test fields done");
  endtask : t_fields

  task automatic t_cfg;
    fifo_enable_low = 1'h0;
    fifo_threshold_field = 4'hA;
    precomp_start_track = 8'h40;
    pulse(cfg_write);
    chk("fifo_on", fifo_on_reg, 1'h1);
    pulse(dsr_reset);
    chk("dsr_rst", {fifo_on_reg, fifo_thr_reg, precomp_reg}, 0);
    pulse(cfg_write);
    lock_value = 1'h1;
    pulse(lock_write);
    pulse(digital_output_register_reset);
    chk("kept", {fifo_on_reg, fifo_thr_reg, precomp_reg}, 13'h1A40);
    lock_value = 1'h0;
    pulse(lock_write);
    pulse(digital_output_register_reset);
    chk("dor_rst", {fifo_on_reg, fifo_thr_reg, precomp_reg}, 0);
    head_load_delay = 7'h01;
    head_unload_delay = 4'h1;
    non_dma_flag = 1'h1;
    pulse(spec_write);
    chk("irq_mode", {irq_per_byte_reg, dma_req_mode_reg}, 2'h2);
    non_dma_flag = 1'h0;
    pulse(spec_write);
    chk("dma_mode", {irq_per_byte_reg, dma_req_mode_reg}, 2'h1);
    $display("test config done");
  endtask : t_cfg

  // one 128-byte sector with a short count; the rest is read silently or padded
  task automatic t_xfer(logic wr, logic seek, logic [7:0] sbc);
    // a latch is only taken when idle, so let a loaded head time out first
    for (int k = 0; k < 40 && head_loaded_reg === 1'h1; k++) tick;
    chk("idle", head_loaded_reg, 1'h0);
    cmd_is_read = !wr;
    cmd_is_write = wr;
    implied_seek_enable = seek;
    cmd_has_cylinder = 1'h1;
    host_wr_data = 8'hA5;
    nbytes = 16'h0080;
    latch(3'h0, sbc, 1'h0, 2'h0);
    {n_crc, n_pass, n_end, n_seek, n_bad} = '0;
    pulse(exec_start);
    for (int k = 0; k < 200 && rw_go_reg !== 1'h1; k++) tick;
    direction_in = 1'h1;
    pulse(cmd_latch);
    chk("xfer_held", step_inward_reg, 1'h0);
    for (int k = 0; k < 1000 && n_end == 0; k++) tick;
    tick(2);
    pulse(exec_end);
    chk("seek_req", n_seek, seek);
    chk("crc_bytes", n_crc, 128);
    chk("host_bytes", n_pass, sbc);
    chk("pad_zero", n_bad, 0);
    chk("sector_end", n_end, 1);
    $display("test transfer done");
  endtask : t_xfer

  task automatic t_unload;
    int k;
    for (k = 0; k < 40 && head_loaded_reg === 1'h1; k++) tick;
    chk("unloaded", head_loaded_reg, 1'h0);
    chk("unload_time", k >= 7 && k <= 10, 1'h1);
    $display("test unload done");
  endtask : t_unload

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // hang guard: the whole sequence needs well under 20000 cycles
  initial begin
    #100000;
    errors++;
    end_sim;
  end

  initial begin
    {rst_n, cmd_latch, cmd_is_read, cmd_is_write, cmd_is_verify, cmd_has_cylinder, direction_in} = '0;
    {drive_select_low, drive_select_high, sector_size_code, special_byte_count, verify_count_enable} = '0;
    {last_sector_number, inter_sector_gap_length, gap_alter, perpendicular_mode, head_side_number} = '0;
    {double_density_select, cfg_write, fifo_enable_low, fifo_threshold_field, precomp_start_track} = '0;
    {implied_seek_enable, lock_write, lock_value, spec_write, head_load_delay, head_unload_delay} = '0;
    {non_dma_flag, dsr_reset, digital_output_register_reset, exec_start, exec_end, host_wr_data, nbytes} = '0;
    ce = 1'h1;
    tick(2);
    rst_n = 1'h1;
    chk("rst_len", {sector_len_reg, host_len_reg}, {15'h80, 15'h80});
    chk("rst_cfg", {dma_req_mode_reg, fifo_on_reg, lock_reg}, 3'h4);
    t_fields;
    t_cfg;
    t_xfer(1'h0, 1'h1, 8'h04);
    t_xfer(1'h1, 1'h0, 8'h10);
    t_unload;
    end_sim;
  end
endmodule : fcpd_param_decode_test

// [fcpd_params.svh]
// constants for the floppy command parameter decoder
// Operation
// [R1] relative seek steps outward when direction bit is 0, inward when 1
// [R2] drive select bits 0,0 address drive 0 and 0,1 address drive 1
// [R3] sector size code zero means 128 bytes, special byte count limits transfer
// [R4] longer sector on read is read whole, only counted bytes go to host
// [R5] longer sector on write is padded with zero bytes after counted bytes
// [R6] sector check code covers the whole physical sector
// [R7] host should set special byte count to all ones for nonzero size code
// [R8] verify with count enable treats special byte count as sectors per track
// [R9] fifo enable is active low, disabled by default
// [R10] implied seek enabled: seek before read or write carrying a cylinder
// [R11] last sector number is the final sector transferred on the track
// [R12] gap alter changes second gap length only in perpendicular mode
// [R13] gap length sets inter-sector gap, excluding the sync field
// [R14] head address selects disk side 0 or 1 as in the sector id
// [R15] wait head load interval after loading head before read or write
// [R16] unload head after head unload interval from end of execution
// [R17] lock decides whether fifo, threshold, precomp revert on software reset
// [R18] software reset comes from data rate select or digital output register
// [R19] density select 1 is double density, 0 single density
// [R20] nonzero size code gives 128 times two to the code, codes up to seven
// [R21] non-dma flag 1 interrupts per transfer, 0 uses dma requests
// [R22] parameters latched in command phase, held through execution
`ifndef FCPD_PARAMS_SVH
`define FCPD_PARAMS_SVH

`define FCPD_CLK_NS          5
`define FCPD_LOAD_UNIT_NS    1000000
`define FCPD_UNLOAD_UNIT_NS  16000000
`define FCPD_LOAD_UNIT_CYC   (`FCPD_LOAD_UNIT_NS / `FCPD_CLK_NS)
`define FCPD_UNLOAD_UNIT_CYC (`FCPD_UNLOAD_UNIT_NS / `FCPD_CLK_NS)
`define FCPD_SECT_BASE_LEN   15'h0080
`define FCPD_SIZE_CODE_MAX   3'h7
`define FCPD_FIFO_OFF_RST    1'h1
`define FCPD_FIFO_THR_RST    4'h0
`define FCPD_PRECOMP_RST     8'h00
`define FCPD_LOCK_RST        1'h0
`define FCPD_HLD_RST         7'h01
`define FCPD_HUD_RST         4'h1

`endif

// [fcpd_pkg.sv]
// types for the floppy command parameter decoder
package fcpd_pkg;
  typedef enum logic [2:0] {
    FCPD_IDLE,
    FCPD_SEEK,
    FCPD_LOAD,
    FCPD_XFER,
    FCPD_HOLD
  } fcpd_state_t;
endpackage : fcpd_pkg
